// >>> hdl/bmc_regs.svh
// Offsets, field positions, reset values and timing counts of the basic mode control block
`ifndef BMC_REGS_SVH
`define BMC_REGS_SVH
`define BMC_BASIC_MODE_CONTROL_OFS 12'h000
`define BMC_BIT_RESET              15
`define BMC_BIT_LOOPBACK           14
`define BMC_BIT_SPEED              13
`define BMC_BIT_AN_ENABLE          12
`define BMC_BIT_POWER_DOWN         11
`define BMC_BIT_ISOLATE            10
`define BMC_BIT_AN_RESTART         9
`define BMC_BIT_DUPLEX             8
`define BMC_DEF_SPEED              1'b1
`define BMC_DEF_AN_ENABLE          1'b1
`define BMC_DEF_DUPLEX             1'b1
`define BMC_SOFT_RESET_NS          1000
`define BMC_CLK_PERIOD_NS          25
`define BMC_SOFT_RESET_CYCLES      ((`BMC_SOFT_RESET_NS + `BMC_CLK_PERIOD_NS - 1) / `BMC_CLK_PERIOD_NS)
`define BMC_RST_CNT_W              6
`define BMC_REG_W                  16
`define BMC_ADDR_W                 12
`define BMC_ZERO16                 16'h0000
`define BMC_ZERO32                 32'h0000_0000
`endif

// >>> hdl/bmc_pkg.sv
// Types shared by the basic mode control block
package bmc_pkg;
   // APB request from the management host
   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } bmc_apb_req_s;

   // APB answer to the management host
   typedef struct packed {
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
   } bmc_apb_rsp_s;

   // Strap levels presented on the configuration inputs
   typedef struct packed {
      logic speed;
      logic an_enable;
      logic duplex;
   } bmc_strap_s;

   // Controls driven to the transceiver core
   typedef struct packed {
      logic soft_reset;
      logic mii_loopback;
      logic speed_100;
      logic full_duplex;
      logic an_enable;
      logic power_down;
      logic mii_isolate;
      logic an_restart;
   } bmc_ctrl_s;

   typedef enum logic [1:0] {
      BMC_AN_IDLE,
      BMC_AN_PENDING
   } bmc_an_e;
endpackage

// >>> hdl/bmc_top.sv
// Basic mode control register of a 10/100 transceiver, reached over APB
//
// Design decision made here: the APB register port.
`timescale 1ns/10ps
`include "bmc_regs.svh"

module bmc_top
   import bmc_pkg::*;
(
   // Clock and reset
   input  wire logic                  core_clk,
   input  wire logic                  rst_n,
   // APB slave
   input  wire bmc_pkg::bmc_apb_req_s apb_req,
   output      bmc_pkg::bmc_apb_rsp_s apb_rsp,
   // Configuration straps and software strap override
   input  wire bmc_pkg::bmc_strap_s   pin_strap,
   input  wire bmc_pkg::bmc_strap_s   software_strap_default,
   input  wire logic                  software_strap_valid,
   // Power-down pin, active low, taken as synchronous
   input  wire logic                  irq_or_powerdown_pin_n,
   // Auto-negotiation engine acknowledges that a restart has begun
   input  wire logic                  an_started,
   // Controls to the transceiver core
   output      bmc_pkg::bmc_ctrl_s    ctrl
);
   import bmc_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   // Reset release
   logic [1:0] rst_sync_q;
   logic       rst_core_n;

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         rst_sync_q <= 2'h0;
      else
         rst_sync_q <= {rst_sync_q[0], 1'b1};
   end
   assign rst_core_n = rst_sync_q[1];

   ////////////////////////////////////////////////////////////////////////////////
   // Helpers
   function automatic bmc_strap_s strap_pick(input bmc_strap_s pin_v, input bmc_strap_s sw_v, input logic sw_ok);
      strap_pick = sw_ok ? sw_v : pin_v;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Register state
   logic                        loop_q,       loop_d;
   logic                        speed_q,      speed_d;
   logic                        an_en_q,      an_en_d;
   logic                        pdn_q,        pdn_d;
   logic                        iso_q,        iso_d;
   logic                        duplex_q,     duplex_d;
   logic                        srst_q,       srst_d;
   logic [`BMC_RST_CNT_W-1:0]   rcnt_q,       rcnt_d;
   logic                        strap_load_q, strap_load_d;
   logic                        boot_q,       boot_d;
   bmc_an_e                     an_q,         an_d;
   bmc_apb_rsp_s                rsp_q,        rsp_d;
   bmc_ctrl_s                   ctrl_q,       ctrl_d;
   logic                        acc;
   logic                        wr_hit;
   logic                        rd_acc;
   logic                        hit;
   logic [`BMC_REG_W-1:0]       wdat;
   logic [`BMC_REG_W-1:0]       rd_val;
   bmc_strap_s                  strap_v;

   ////////////////////////////////////////////////////////////////////////////////
   // Bus decode
   always_comb
   begin
      hit     = (apb_req.paddr == `BMC_BASIC_MODE_CONTROL_OFS);
      acc     = apb_req.psel && apb_req.penable;
      // A write lands only at the edge that sees pready high
      wr_hit  = acc && apb_req.pwrite && hit && rsp_q.pready && !srst_q;
      rd_acc  = acc && !apb_req.pwrite && hit && !rsp_q.pready;
      wdat    = apb_req.pwdata[`BMC_REG_W-1:0];
      strap_v = strap_pick(pin_strap, software_strap_default, software_strap_valid);
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Soft reset sequencer and strap relatch
   always_comb
   begin
      srst_d       = srst_q;
      rcnt_d       = rcnt_q;
      strap_load_d = boot_q;
      boot_d       = 1'b0;

      if (wr_hit && wdat[`BMC_BIT_RESET])
      begin
         srst_d = 1'b1;
         rcnt_d = `BMC_RST_CNT_W'(`BMC_SOFT_RESET_CYCLES);
      end

      // Count runs down, then bit 15 clears and straps are relatched
      if (srst_q)
      begin
         if (rcnt_q == `BMC_RST_CNT_W'(1))
         begin
            srst_d       = 1'b0;
            strap_load_d = 1'b1;
         end
         rcnt_d = rcnt_q - `BMC_RST_CNT_W'(1);
      end
   end

   always_ff @(posedge core_clk or negedge rst_core_n)
   begin
      if (!rst_core_n)
      begin
         srst_q       <= 1'b0;
         rcnt_q       <= '0;
         strap_load_q <= 1'b0;
         boot_q       <= 1'b1;
      end
      else
      begin
         srst_q       <= srst_d;
         rcnt_q       <= rcnt_d;
         strap_load_q <= strap_load_d;
         boot_q       <= boot_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Plain control bits
   always_comb
   begin
      loop_d   = loop_q;
      speed_d  = speed_q;
      an_en_d  = an_en_q;
      pdn_d    = pdn_q;
      iso_d    = iso_q;
      duplex_d = duplex_q;

      if (wr_hit)
      begin
         loop_d   = wdat[`BMC_BIT_LOOPBACK];
         speed_d  = wdat[`BMC_BIT_SPEED];
         an_en_d  = wdat[`BMC_BIT_AN_ENABLE];
         pdn_d    = wdat[`BMC_BIT_POWER_DOWN];
         iso_d    = wdat[`BMC_BIT_ISOLATE];
         duplex_d = wdat[`BMC_BIT_DUPLEX];
      end

      if (strap_load_q)
      begin
         loop_d   = 1'b0;
         pdn_d    = 1'b0;
         iso_d    = 1'b0;
         speed_d  = strap_v.speed;
         an_en_d  = strap_v.an_enable;
         duplex_d = strap_v.duplex;
      end

      // Pin wins over a write of zero in the same cycle
      if (!irq_or_powerdown_pin_n)
         pdn_d = 1'b1;
   end

   always_ff @(posedge core_clk or negedge rst_core_n)
   begin
      if (!rst_core_n)
      begin
         loop_q   <= 1'b0;
         speed_q  <= `BMC_DEF_SPEED;
         an_en_q  <= `BMC_DEF_AN_ENABLE;
         pdn_q    <= 1'b0;
         iso_q    <= 1'b0;
         duplex_q <= `BMC_DEF_DUPLEX;
      end
      else
      begin
         loop_q   <= loop_d;
         speed_q  <= speed_d;
         an_en_q  <= an_en_d;
         pdn_q    <= pdn_d;
         iso_q    <= iso_d;
         duplex_q <= duplex_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Auto-negotiation restart
   always_comb
   begin
      an_d = an_q;
      unique case (an_q)
         BMC_AN_IDLE:
            // Only a one can start a restart; a zero leaves a pending one alone
            if (wr_hit && wdat[`BMC_BIT_AN_RESTART] && an_en_q)
               an_d = BMC_AN_PENDING;
         BMC_AN_PENDING:
            if (an_started)
               an_d = BMC_AN_IDLE;
         default:
            an_d = BMC_AN_IDLE;
      endcase
      if (strap_load_q)
         an_d = BMC_AN_IDLE;
   end

   always_ff @(posedge core_clk or negedge rst_core_n)
   begin
      if (!rst_core_n)
         an_q <= BMC_AN_IDLE;
      else
         an_q <= an_d;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Read value
   always_comb
   begin
      rd_val                      = `BMC_ZERO16;
      rd_val[`BMC_BIT_RESET]      = srst_q;
      rd_val[`BMC_BIT_LOOPBACK]   = loop_q;
      rd_val[`BMC_BIT_SPEED]      = speed_q;
      rd_val[`BMC_BIT_AN_ENABLE]  = an_en_q;
      rd_val[`BMC_BIT_POWER_DOWN] = pdn_q;
      rd_val[`BMC_BIT_ISOLATE]    = iso_q;
      rd_val[`BMC_BIT_AN_RESTART] = (an_q == BMC_AN_PENDING);
      rd_val[`BMC_BIT_DUPLEX]     = duplex_q;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // APB answer one cycle after the access phase begins
   always_comb
   begin
      rsp_d         = '0;
      rsp_d.pready  = acc && !rsp_q.pready;
      rsp_d.pslverr = acc && !rsp_q.pready && !hit;
      rsp_d.prdata  = rd_acc ? {`BMC_ZERO16, rd_val} : `BMC_ZERO32;
   end

   always_ff @(posedge core_clk or negedge rst_core_n)
   begin
      if (!rst_core_n)
         rsp_q <= '0;
      else
         rsp_q <= rsp_d;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Controls to the transceiver core
   always_comb
   begin
      ctrl_d              = '0;
      ctrl_d.soft_reset   = srst_d;
      ctrl_d.mii_loopback = loop_d;
      ctrl_d.an_enable    = an_en_d;
      ctrl_d.speed_100    = an_en_d ? 1'b1 : speed_d;
      ctrl_d.full_duplex  = an_en_d ? 1'b1 : duplex_d;
      ctrl_d.power_down   = pdn_d || !irq_or_powerdown_pin_n;
      ctrl_d.mii_isolate  = iso_d;
      ctrl_d.an_restart   = (an_d == BMC_AN_PENDING);
   end

   always_ff @(posedge core_clk or negedge rst_core_n)
   begin
      if (!rst_core_n)
         ctrl_q <= '0;
      else
         ctrl_q <= ctrl_d;
   end

   assign apb_rsp = rsp_q;
   assign ctrl    = ctrl_q;
endmodule

// >>> verif/bmc_an_model.sv
// Auto-negotiation engine model that acknowledges a restart after a delay
`timescale 1ns/10ps
module bmc_an_model #(parameter int DLY = 20)
(
   input  wire logic core_clk,
   input  wire logic rst_n,
   input  wire logic restart,
   output      logic started
);
   int cnt;
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         cnt <= 0;
      else
         cnt <= restart ? cnt + 1 : 0;
   end
   // Single-cycle acknowledge, late enough that the pending state can be read
   assign started = (cnt == DLY);
endmodule

// >>> verif/bmc_top_asserts.sv
// Port assertions of the basic mode control block
`timescale 1ns/10ps
module bmc_top_asserts
   import bmc_pkg::*;
(
   input wire logic                  core_clk,
   input wire logic                  rst_n,
   input wire bmc_pkg::bmc_apb_req_s apb_req,
   input wire bmc_pkg::bmc_apb_rsp_s apb_rsp,
   input wire logic                  irq_or_powerdown_pin_n,
   input wire logic                  an_started,
   input wire bmc_pkg::bmc_ctrl_s    ctrl
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   sequence s_access;
      apb_req.psel && $rose(apb_req.penable);
   endsequence
   sequence s_sreset;
      $rose(ctrl.soft_reset);
   endsequence
   ////////////////////////////////////////////////////////////////////////////
   chk_ready_time: assert property (s_access |=> apb_rsp.pready)
      else $error("pready not one cycle after access");
   chk_ready_pulse: assert property (apb_rsp.pready |=> !apb_rsp.pready)
      else $error("pready longer than one cycle");
   chk_upper_zero: assert property (apb_rsp.pready |-> apb_rsp.prdata[31:16] == 16'h0000)
      else $error("upper read half not zero");
   chk_bad_addr: assert property (apb_rsp.pready |-> apb_rsp.pslverr == (apb_req.paddr != 12'h000))
      else $error("pslverr wrong for address");
   chk_sreset_len: assert property (s_sreset |-> ctrl.soft_reset [*8] ##31 ctrl.soft_reset ##[1:3] !ctrl.soft_reset)
      else $error("soft reset length wrong");
   chk_relatch_clear: assert property ($fell(ctrl.soft_reset) |-> ##[1:2] !ctrl.mii_loopback && !ctrl.mii_isolate)
      else $error("controls not cleared after soft reset");
   chk_an_forced: assert property (ctrl.an_enable |-> ctrl.speed_100 && ctrl.full_duplex)
      else $error("speed or duplex not overridden");
   chk_pin_pdown: assert property (!irq_or_powerdown_pin_n && $past(rst_n, 3) |-> ##[0:2] ctrl.power_down)
      else $error("pin does not power down");
   chk_an_gate: assert property ($rose(ctrl.an_restart) |-> ctrl.an_enable)
      else $error("restart with negotiation off");
   chk_an_clear: assert property (ctrl.an_restart && an_started |-> ##[1:2] !ctrl.an_restart)
      else $error("restart not cleared");
endmodule
bind bmc_top bmc_top_asserts u_chk (.core_clk(core_clk), .rst_n(rst_n), .apb_req(apb_req), .apb_rsp(apb_rsp),
   .irq_or_powerdown_pin_n(irq_or_powerdown_pin_n), .an_started(an_started), .ctrl(ctrl));

// >>> verif/test_phy_basic_mode_control.sv
// Self-checking bench for the basic mode control register
`timescale 1ns/10ps
module test_phy_basic_mode_control;
   import bmc_pkg::*;
   logic         core_clk = 1'b0;
   logic         rst_n = 1'b0;
   logic         sws_ok = 1'b0;
   logic         pd_n = 1'b1;
   logic         an_go;
   logic         err;
   logic [31:0]  q;
   bmc_apb_req_s req = '0;
   bmc_apb_rsp_s rsp;
   bmc_strap_s   pin = 3'b101;
   bmc_strap_s   sws = 3'b010;
   bmc_ctrl_s    ctrl;
   int           n_mismatch = 0;
   int           samples_checked = 0;
   bmc_top uut (.core_clk(core_clk), .rst_n(rst_n), .apb_req(req), .apb_rsp(rsp), .pin_strap(pin),
      .software_strap_default(sws), .software_strap_valid(sws_ok), .irq_or_powerdown_pin_n(pd_n),
      .an_started(an_go), .ctrl(ctrl));
   bmc_an_model u_an (.core_clk(core_clk), .rst_n(rst_n), .restart(ctrl.an_restart), .started(an_go));
   initial forever #12.5 core_clk = ~core_clk;
   initial
   begin
      #125000;
      n_mismatch++;
      conclude();
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic conclude();
      if (n_mismatch == 0 && samples_checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      samples_checked++;
      if (s !== e)
      begin
         n_mismatch++;
         $display("FAIL %s exp %h seen %h", nm, e, s);
      end
   endtask
   task automatic xfer(input logic w, input logic [11:0] a, input logic [15:0] d);
      @(posedge core_clk);
      req <= '{1'b1, 1'b0, w, a, {16'h0000, d}};
      @(posedge core_clk);
      req.penable <= 1'b1;
      do
         @(posedge core_clk);
      while (rsp.pready !== 1'b1);
      q = rsp.prdata;
      err = rsp.pslverr;
      req <= '0;
   endtask
   task automatic rc(input logic [11:0] a, input logic [15:0] e);
      xfer(1'b0, a, 16'h0000);
      chk("bmc", q, {16'h0000, e});
   endtask
   task automatic cc(input logic [7:0] e);
      chk("ctrl", {24'h000000, ctrl}, {24'h000000, e});
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (20) @(posedge core_clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge core_clk);
      rc(12'h000, 16'h2100);
      cc(8'h30);
      xfer(1'b1, 12'h000, 16'h0000);
      rc(12'h000, 16'h0000);
      cc(8'h00);
      xfer(1'b1, 12'h000, 16'h0200);
      rc(12'h000, 16'h0000);
      xfer(1'b1, 12'h000, 16'h7400);
      rc(12'h000, 16'h7400);
      cc(8'h7a);
      xfer(1'b1, 12'h000, 16'h7600);
      rc(12'h000, 16'h7600);
      xfer(1'b1, 12'h000, 16'h7400);
      rc(12'h000, 16'h7600);
      repeat (30) @(posedge core_clk);
      rc(12'h000, 16'h7400);
      xfer(1'b1, 12'h000, 16'h7c00);
      rc(12'h000, 16'h7c00);
      cc(8'h7e);
      xfer(1'b1, 12'h000, 16'h7400);
      pd_n <= 1'b0;
      rc(12'h000, 16'h7c00);
      cc(8'h7e);
      pd_n <= 1'b1;
      xfer(1'b1, 12'h000, 16'h7400);
      rc(12'h000, 16'h7400);
      cc(8'h7a);
      xfer(1'b1, 12'h004, 16'h0000);
      chk("pslverr", {31'h00000000, err}, 32'h0000_0001);
      rc(12'h004, 16'h0000);
      rc(12'h000, 16'h7400);
      sws_ok <= 1'b1;
      xfer(1'b1, 12'h000, 16'hf400);
      xfer(1'b1, 12'h000, 16'h0000);
      rc(12'h000, 16'hf400);
      cc(8'hfa);
      repeat (40) @(posedge core_clk);
      rc(12'h000, 16'h1000);
      cc(8'h38);
      conclude();
   end
endmodule
